// ---- bsd_host.sv ----
// Top of the duplicator host: sequencer, AHB-Lite register slave.
// Assumes pins serial_rx and prog_voltage_sense are asynchronous.
`timescale 1ns/1ps
module bsd_host
  import bsd_pkg::*;
#(
  parameter int unsigned VPP_WAIT = VPP_CYC,
  parameter int unsigned PAUSE_WAIT = PAUSE_CYC,
  parameter int unsigned BIT_WAIT = BIT_CYC
)
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             target_reset_out,
  output logic             serial_tx,
  output logic             serial_tx_oen,
  input  wire logic        serial_rx,
  input  wire logic        prog_voltage_sense,
  output logic             led_red,
  output logic             led_green
);
  typedef enum logic [8:0] {
    S_IDLE  = 9'h001, S_BRK   = 9'h002, S_LEAD  = 9'h004,
    S_BOOT  = 9'h008, S_PAUSE = 9'h010, S_VPP   = 9'h020,
    S_RDY   = 9'h040, S_DATA  = 9'h080, S_DONE  = 9'h100
  } bsd_state_e;

  bsd_state_e      st_reg, st_next;
  logic [31:0]     tmr_reg, tmr_next;
  logic [ADDR_W:0] sent_reg, sent_next;
  logic [ADDR_W:0] ver_reg, ver_next;
  logic [2:0]      bidx_reg, bidx_next;
  logic            rel_reg, rel_next;
  logic            red_reg, red_next;
  logic            grn_reg, grn_next;
  logic            pass_reg, pass_next;
  logic            fail_reg, fail_next;
  logic            go_reg, go_next;
  logic [7:0]      exp_reg [2];
  logic [7:0]      exp0_next, exp1_next;
  logic            fetch_reg, fetch_next;
  logic [1:0]      rx_sync_reg, vpp_sync_reg;
  logic            rx_s, vpp_s;
  logic            tx_start;
  logic [7:0]      tx_data;
  logic            tx_busy, tx_line;
  logic            rx_valid, rdy_char;
  logic            seen_reg, seen_next;
  logic [7:0]      rx_data;
  logic [7:0]      mem_rdata;
  logic            mem_we;
  logic            a_ph_reg, a_wr_reg;
  logic [7:0]      a_off_reg;
  logic [31:0]     hrdata_next;

  // Increment helper for byte counters
  function automatic logic [ADDR_W:0] inc(input logic [ADDR_W:0] v);
    return v + {{ADDR_W{1'b0}}, 1'b1};
  endfunction

  // Pin synchronisers; first stage read only by second
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_reg  <= 2'b11;
      vpp_sync_reg <= 2'b00;
    end else if (ce) begin
      rx_sync_reg  <= {rx_sync_reg[0], serial_rx};
      vpp_sync_reg <= {vpp_sync_reg[0], prog_voltage_sense};
    end
  end
  assign rx_s  = rx_sync_reg[1];
  assign vpp_s = vpp_sync_reg[1];

  bsd_uart #(.BIT_T(BIT_WAIT)) u_uart (
    .clk      (clk),
    .rstn     (rstn),
    .ce       (ce),
    .tx_start (tx_start),
    .tx_data  (tx_data),
    .tx_busy  (tx_busy),
    .tx_line  (tx_line),
    .rx_line  (rx_s),
    .rx_valid (rx_valid),
    .rx_data  (rx_data)
  );

  // Image writes come from the bus data window, any address with bit 16 set (0x10000) or with low byte 0xFF
  assign mem_we = a_ph_reg && a_wr_reg && a_off_reg == 8'hFF;
  bsd_image_mem u_mem (
    .clk   (clk),
    .ce    (ce),
    .we    (mem_we),
    .waddr (hwdata[ADDR_W+7:8]),
    .wdata (hwdata[7:0]),
    .raddr (sent_reg[ADDR_W-1:0]),
    .rdata (mem_rdata)
  );

  // Outputs
  assign target_reset_out = rel_reg;
  assign serial_tx        = tx_line;
  assign serial_tx_oen    = 1'b0;
  assign led_red          = red_reg;
  assign led_green        = grn_reg;
  assign hreadyout        = 1'b1;
  assign hresp            = 1'b0;
  assign rdy_char         = rx_valid && rx_data == LEAD_CHAR; // Ready mark

  // Sequencer next state
  always_comb begin
    st_next    = st_reg;
    tmr_next   = tmr_reg;
    sent_next  = sent_reg;
    ver_next   = ver_reg;
    bidx_next  = bidx_reg;
    rel_next   = rel_reg;
    red_next   = red_reg;
    grn_next   = grn_reg;
    pass_next  = pass_reg;
    fail_next  = fail_reg;
    exp0_next  = exp_reg[0];
    exp1_next  = exp_reg[1];
    fetch_next = 1'b0;
    seen_next  = seen_reg;
    tx_start   = 1'b0;
    tx_data    = LEAD_CHAR;
    unique case (st_reg)
      S_IDLE: begin
        if (go_reg) begin
          rel_next  = 1'b1;
          red_next  = 1'b0;
          grn_next  = 1'b0;
          pass_next = 1'b0;
          fail_next = 1'b0;
          seen_next = 1'b0;
          st_next   = S_BRK;
        end
      end
      S_BRK: begin
        if (rx_valid) begin
          st_next = S_LEAD;
        end
      end
      S_LEAD: begin
        if (!tx_busy) begin
          tx_start  = 1'b1;
          bidx_next = 3'h0;
          st_next   = S_BOOT;
        end
      end
      S_BOOT: begin
        if (!tx_busy) begin
          tx_start  = 1'b1;
          tx_data   = BOOT_PROG[bidx_reg];
          bidx_next = bidx_reg + 3'h1;
          if (bidx_reg == 3'(BOOT_LEN - 1)) begin
            tmr_next = 32'h0;
            st_next  = S_PAUSE;
          end
        end
      end
      S_PAUSE: begin
        tmr_next = tmr_reg + 32'h1;
        seen_next = seen_reg || rdy_char; // Early ready mark kept
        if (tmr_reg >= 32'(PAUSE_WAIT)) begin
          tmr_next = 32'h0;
          st_next  = S_VPP;
        end
      end
      S_VPP: begin
        seen_next = seen_reg || rdy_char;
        if (!vpp_s) begin
          tmr_next = 32'h0;
        end else if (tmr_reg >= 32'(VPP_WAIT - 1)) begin
          red_next  = 1'b1;
          sent_next = '0;
          ver_next  = '0;
          st_next   = S_RDY;
        end else begin
          tmr_next = tmr_reg + 32'h1;
        end
      end
      S_RDY: begin
        if (seen_reg || rdy_char) begin
          fetch_next = 1'b1;
          st_next    = S_DATA;
        end
      end
      S_DATA: begin
        // Keep at most two bytes outstanding
        if (fetch_reg && !tx_busy && sent_reg < IMAGE_BYTES[ADDR_W:0]
            && sent_reg - ver_reg < 2) begin
          tx_start  = 1'b1;
          tx_data   = mem_rdata;
          exp0_next = sent_reg[0] ? exp_reg[0] : mem_rdata;
          exp1_next = sent_reg[0] ? mem_rdata : exp_reg[1];
          sent_next = inc(sent_reg);
        end
        fetch_next = !tx_start;
        if (rx_valid) begin
          if (rx_data != exp_reg[ver_reg[0]]) begin
            red_next  = 1'b0;
            grn_next  = 1'b0;
            fail_next = 1'b1;
            rel_next  = 1'b0;
            st_next   = S_DONE;
          end else begin
            ver_next = inc(ver_reg);
            if (inc(ver_reg) == IMAGE_BYTES[ADDR_W:0]) begin
              red_next  = 1'b0;
              grn_next  = 1'b1;
              pass_next = 1'b1;
              rel_next  = 1'b0;
              st_next   = S_DONE;
            end
          end
        end
      end
      S_DONE: begin
        if (!go_reg) begin
          st_next = S_IDLE;
        end
      end
    endcase
  end

  // Sequencer registers; target held in reset while host resets
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg     <= S_IDLE;
      tmr_reg    <= 32'h0;
      sent_reg   <= '0;
      ver_reg    <= '0;
      bidx_reg   <= 3'h0;
      rel_reg    <= 1'b0;
      red_reg    <= 1'b0;
      grn_reg    <= 1'b0;
      pass_reg   <= 1'b0;
      fail_reg   <= 1'b0;
      exp_reg[0] <= 8'h00;
      exp_reg[1] <= 8'h00;
      fetch_reg  <= 1'b0;
      seen_reg   <= 1'b0;
    end else if (ce) begin
      st_reg     <= st_next;
      tmr_reg    <= tmr_next;
      sent_reg   <= sent_next;
      ver_reg    <= ver_next;
      bidx_reg   <= bidx_next;
      rel_reg    <= rel_next;
      red_reg    <= red_next;
      grn_reg    <= grn_next;
      pass_reg   <= pass_next;
      fail_reg   <= fail_next;
      exp_reg[0] <= exp0_next;
      exp_reg[1] <= exp1_next;
      fetch_reg  <= fetch_next;
      seen_reg   <= seen_next;
    end
  end

  // Bus slave: control write, status and progress reads
  always_comb begin
    go_next     = go_reg;
    hrdata_next = hrdata;
    if (a_ph_reg && a_wr_reg && a_off_reg == CTRL_OFF) begin
      go_next = hwdata[CTRL_GO_BIT];
    end
    if (hsel && hready && htrans[1] && !hwrite) begin
      unique case (haddr[7:0])
        CTRL_OFF:  hrdata_next = {31'h0, go_next};
        STAT_OFF:  hrdata_next = {26'h0, rel_reg, grn_reg, red_reg,
                                  fail_reg, pass_reg, st_reg != S_IDLE};
        COUNT_OFF: hrdata_next = {{(31-ADDR_W){1'b0}}, ver_reg};
        default:   hrdata_next = 32'h0;
      endcase
    end
  end

  // Bus slave registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      go_reg    <= 1'b0;
      hrdata    <= 32'h0;
      a_ph_reg  <= 1'b0;
      a_wr_reg  <= 1'b0;
      a_off_reg <= 8'h00;
    end else if (ce) begin
      go_reg    <= go_next;
      hrdata    <= hrdata_next;
      a_ph_reg  <= hsel && hready && htrans[1];
      a_wr_reg  <= hwrite;
      a_off_reg <= haddr[16] ? 8'hFF : haddr[7:0];
    end
  end

  property p_no_release_idle;
    @(posedge clk) disable iff (!rstn)
      st_reg == S_IDLE && !go_reg |=> !target_reset_out;
  endproperty
  a_no_release_idle: assert property (p_no_release_idle)
    else $error("target released while idle");

  property p_red_after_vpp;
    @(posedge clk) disable iff (!rstn)
      ce && st_reg == S_VPP && !vpp_s |=> !red_reg;
  endproperty
  a_red_after_vpp: assert property (p_red_after_vpp)
    else $error("red lit without qualified voltage");

  property p_timer_restart;
    @(posedge clk) disable iff (!rstn)
      ce && st_reg == S_VPP && !vpp_s |=> tmr_reg == 32'h0;
  endproperty
  a_timer_restart: assert property (p_timer_restart)
    else $error("voltage timer not restarted");

  property p_fail_leds;
    @(posedge clk) disable iff (!rstn)
      $rose(fail_reg) |-> !led_red && !led_green && !target_reset_out;
  endproperty
  a_fail_leds: assert property (p_fail_leds)
    else $error("fail indicators wrong");

  property p_pass_leds;
    @(posedge clk) disable iff (!rstn)
      $rose(pass_reg) |-> !led_red && led_green && !target_reset_out;
  endproperty
  a_pass_leds: assert property (p_pass_leds)
    else $error("pass indicators wrong");

  property p_window;
    @(posedge clk) disable iff (!rstn)
      sent_reg - ver_reg <= 2;
  endproperty
  a_window: assert property (p_window)
    else $error("more than two bytes outstanding");

  property p_lead_first;
    @(posedge clk) disable iff (!rstn)
      st_reg == S_LEAD && tx_start |-> tx_data == LEAD_CHAR;
  endproperty
  a_lead_first: assert property (p_lead_first)
    else $error("leading character not all ones");

  property p_tx_driven;
    @(posedge clk) disable iff (!rstn)
      !serial_tx_oen;
  endproperty
  a_tx_driven: assert property (p_tx_driven)
    else $error("transmit not actively driven");

  c_pass: cover property (@(posedge clk) $rose(pass_reg));
  c_fail: cover property (@(posedge clk) $rose(fail_reg));
  c_vpp_drop: cover property (@(posedge clk)
    st_reg == S_VPP && tmr_reg > 0 && !vpp_s);
endmodule // bsd_host

// ---- bsd_pkg.sv ----
// Package of constants for the boot serial duplicator host.
// Assumes one 200 MHz clock; UART framing 8N1 at a fixed bit rate.
package bsd_pkg;
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned BAUD          = 7_812;
  localparam int unsigned BIT_CYC       = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC      = BIT_CYC / 2;
  localparam int unsigned VPP_MS        = 200;
  localparam int unsigned VPP_CYC       = VPP_MS * (CLK_HZ / 1000);
  localparam int unsigned PAUSE_CHARS   = 4;
  localparam int unsigned PAUSE_CYC     = PAUSE_CHARS * 10 * BIT_CYC;
  localparam int unsigned IMAGE_BYTES   = 12288;
  localparam int unsigned ADDR_W        = 14;
  localparam logic [7:0]  LEAD_CHAR     = 8'hFF;
  localparam int unsigned BOOT_LEN      = 8;
  // Register offsets
  localparam logic [7:0]  CTRL_OFF      = 8'h00;
  localparam logic [7:0]  STAT_OFF      = 8'h04;
  localparam logic [7:0]  COUNT_OFF     = 8'h08;
  localparam int unsigned CTRL_GO_BIT   = 0;
  // Status field positions
  localparam int unsigned ST_BUSY_BIT   = 0;
  localparam int unsigned ST_PASS_BIT   = 1;
  localparam int unsigned ST_FAIL_BIT   = 2;
  localparam int unsigned ST_RED_BIT    = 3;
  localparam int unsigned ST_GREEN_BIT  = 4;
  localparam int unsigned ST_RST_BIT    = 5;
  // Downloaded program: clear wired-OR, jump to programming utility
  localparam logic [7:0]  BOOT_PROG [BOOT_LEN] = '{8'h86, 8'h04, 8'h97,
      8'h28, 8'h7E, 8'hBF, 8'h00, 8'h01};
endpackage

// ---- bsd_image_mem.sv ----
// Image memory holding the bytes to program into the target.
// Assumes the loader writes it over the register bus; read data registered.
`timescale 1ns/1ps
module bsd_image_mem
  import bsd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              ce,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic      [7:0]        rdata
);
  logic [7:0] mem [IMAGE_BYTES];

  // Synchronous write and registered read
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // bsd_image_mem

// ---- bsd_uart.sv ----
// Plain 8N1 serial transmitter and receiver.
// Assumes rx is already synchronised; start/valid are same-clock pulses.
`timescale 1ns/1ps
module bsd_uart
  import bsd_pkg::*;
#(
  parameter int unsigned BIT_T = BIT_CYC
)
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ce,
  input  wire logic       tx_start,
  input  wire logic [7:0] tx_data,
  output logic            tx_busy,
  output logic            tx_line,
  input  wire logic       rx_line,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic [15:0] tcnt_reg, tcnt_next;
  logic [3:0]  tbit_reg, tbit_next;
  logic [9:0]  tsh_reg,  tsh_next;
  logic [15:0] rcnt_reg, rcnt_next;
  logic [3:0]  rbit_reg, rbit_next;
  logic [8:0]  rsh_reg,  rsh_next;
  logic        rbusy_reg, rbusy_next;
  logic        rv_reg, rv_next;

  assign tx_busy  = (tbit_reg != 4'h0);
  assign tx_line  = tsh_reg[0];
  assign rx_valid = rv_reg;
  assign rx_data  = rsh_reg[7:0];

  // Transmit shifter and receive sampler next state
  always_comb begin
    tcnt_next  = tcnt_reg;
    tbit_next  = tbit_reg;
    tsh_next   = tsh_reg;
    rcnt_next  = rcnt_reg;
    rbit_next  = rbit_reg;
    rsh_next   = rsh_reg;
    rbusy_next = rbusy_reg;
    rv_next    = 1'b0;
    if (tbit_reg == 4'h0) begin
      if (tx_start) begin
        tsh_next  = {1'b1, tx_data, 1'b0};
        tbit_next = 4'hA;
        tcnt_next = 16'(BIT_T - 1);
      end
    end else if (tcnt_reg == 16'h0000) begin
      tsh_next  = {1'b1, tsh_reg[9:1]};
      tbit_next = tbit_reg - 4'h1;
      tcnt_next = 16'(BIT_T - 1);
    end else begin
      tcnt_next = tcnt_reg - 16'h0001;
    end
    if (!rbusy_reg) begin
      if (!rx_line) begin
        rbusy_next = 1'b1;
        rbit_next  = 4'h9;
        rcnt_next  = 16'(BIT_T / 2 + BIT_T - 1);
      end
    end else if (rcnt_reg == 16'h0000) begin
      rsh_next  = {rx_line, rsh_reg[8:1]};
      rbit_next = rbit_reg - 4'h1;
      rcnt_next = 16'(BIT_T - 1);
      if (rbit_reg == 4'h1) begin
        rbusy_next = 1'b0;
        rv_next    = 1'b1;
      end
    end else begin
      rcnt_next = rcnt_reg - 16'h0001;
    end
  end

  // Registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tcnt_reg  <= 16'h0000;
      tbit_reg  <= 4'h0;
      tsh_reg   <= 10'h3FF;
      rcnt_reg  <= 16'h0000;
      rbit_reg  <= 4'h0;
      rsh_reg   <= 9'h000;
      rbusy_reg <= 1'b0;
      rv_reg    <= 1'b0;
    end else if (ce) begin
      tcnt_reg  <= tcnt_next;
      tbit_reg  <= tbit_next;
      tsh_reg   <= tsh_next;
      rcnt_reg  <= rcnt_next;
      rbit_reg  <= rbit_next;
      rsh_reg   <= rsh_next;
      rbusy_reg <= rbusy_next;
      rv_reg    <= rv_next;
    end
  end
endmodule // bsd_uart

// ---- bsd_target_model.sv ----
// Behavioural target controller running its serial boot loader.
// Assumes 8N1 framing at a parameter bit time and one shared clock.
`timescale 1ns/1ps
module bsd_target_model
  import bsd_pkg::*;
#(
  parameter int unsigned BIT_T     = BIT_CYC,
  parameter int unsigned PAUSE_DET = BIT_T / 2 + 1000,
  parameter int unsigned PROG_CYC  = 200,
  parameter logic [15:0] START     = 16'hD000
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        rx_line,
  input  wire logic [15:0] bad_index,
  output logic             tx_line,
  output logic             rx_stb,
  output logic [7:0]       rx_byte,
  output logic [15:0]      echo_cnt
);
  logic [7:0]  rx_q[$];
  logic        rx_busy;
  logic [7:0]  b_rx;
  logic [7:0]  b_tx;
  logic [15:0] addr;
  int          idle;

  // One frame, start bit first, low bit first
  task automatic send_frame(input logic [9:0] f);
    for (int i = 0; i < 10; i++) begin
      tx_line <= f[i];
      repeat (BIT_T) @(posedge clk);
    end
    tx_line <= 1'b1;
  endtask

  // Receiver samples mid-bit and strobes at the stop bit
  initial begin
    rx_stb  = 1'b0;
    rx_busy = 1'b0;
    rx_byte = 8'h00;
    b_rx    = 8'h00;
    forever begin
      @(posedge clk);
      rx_stb <= 1'b0;
      if (reset_n === 1'b1 && rx_line === 1'b0) begin
        rx_busy = 1'b1;
        repeat (BIT_T / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_T) @(posedge clk);
          b_rx[i] = rx_line;
        end
        repeat (BIT_T) @(posedge clk);
        rx_q.push_back(b_rx);
        rx_byte <= b_rx;
        rx_stb  <= 1'b1;
        rx_busy = 1'b0;
      end
    end
  end

  // Loader, then programming loop echoing each byte
  initial begin
    tx_line  = 1'b1;
    echo_cnt = 16'h0000;
    addr     = START;
    idle     = 0;
    do @(posedge clk); while (reset_n !== 1'b1);
    repeat (10) @(posedge clk);
    send_frame(10'h000);
    while (idle < PAUSE_DET || rx_q.size() < 2) begin
      @(posedge clk);
      idle = (rx_busy || rx_line !== 1'b1) ? 0 : idle + 1;
    end
    rx_q.delete();
    send_frame({1'b1, 8'hFF, 1'b0});
    forever begin
      do @(posedge clk); while (rx_q.size() == 0);
      b_tx = rx_q.pop_front();
      if (echo_cnt == bad_index)
        b_tx = ~b_tx;
      addr = addr + 16'h0001;
      repeat (PROG_CYC) @(posedge clk);
      send_frame({1'b1, b_tx, 1'b0});
      echo_cnt <= echo_cnt + 16'h0001;
    end
  end
endmodule // bsd_target_model

// ---- testbench.sv ----
// Self-checking bench for the duplicator host with a target model.
// Assumes bit time, voltage and pause counts shortened for speed.
`timescale 1ns/1ps
module testbench
  import bsd_pkg::*;
;
  localparam int unsigned VPP_T = 100;
  localparam int unsigned BIT_T = 64;
  logic        clk, rstn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        target_reset_out, serial_tx, serial_tx_oen, serial_rx;
  logic        prog_voltage_sense, led_red, led_green, rx_stb;
  logic [7:0]  rx_byte, lfsr;
  logic [15:0] echo_cnt, bad_index;
  logic [7:0]  exp_q[$];
  int          n_fail, cmp_count, n_rx;

  bsd_host #(.VPP_WAIT(VPP_T), .PAUSE_WAIT(2000), .BIT_WAIT(BIT_T)) u_dut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .target_reset_out(target_reset_out),
    .serial_tx(serial_tx), .serial_tx_oen(serial_tx_oen),
    .serial_rx(serial_rx), .prog_voltage_sense(prog_voltage_sense),
    .led_red(led_red), .led_green(led_green));

  bsd_target_model #(.BIT_T(BIT_T)) u_tgt (
    .clk(clk), .reset_n(target_reset_out), .rx_line(serial_tx),
    .bad_index(bad_index), .tx_line(serial_rx), .rx_stb(rx_stb),
    .rx_byte(rx_byte), .echo_cnt(echo_cnt));

  // Clock at 200 MHz
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic bit done(input int sel, input int lim);
    case (sel)
      0: return target_reset_out === lim[0];
      1: return led_red === 1'b1;
      3: return hreadyout === 1'b1;
      default: return n_rx >= lim;
    endcase
  endfunction

  // Bounded wait; running out ends the run as a failure
  task automatic wait_for(input int sel, input int lim, input int bound);
    int n;
    n = 0;
    while (!done(sel, lim) && n < bound) begin
      @(posedge clk);
      n++;
    end
    if (!done(sel, lim)) begin
      $display("wrong value wait %0d expected done seen timeout", sel);
      n_fail++;
      results();
    end
  endtask

  // Single AHB-Lite word transfer, each phase held until hready
  task automatic ahb(input logic wr, input logic [31:0] a,
                     input logic [31:0] wd, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize  <= 3'b010;
    @(posedge clk);
    wait_for(3, 0, 100);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    wait_for(3, 0, 100);
    r = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // Bench model of the host byte stream, checked per byte
  always @(posedge clk) begin
    if (rx_stb === 1'b1) begin
      chk("tx byte", {24'h0, exp_q[n_rx]}, {24'h0, rx_byte});
      if (n_rx == 10)
        chk("echo before 2nd", 32'h0, {16'h0, echo_cnt});
      n_rx++;
    end
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0;
    prog_voltage_sense = 1'b0;
    bad_index = 16'h0001;
    n_fail = 0;
    cmp_count = 0;
    n_rx = 0;
    lfsr = 8'h3B;
    repeat (3) @(posedge clk);
    chk("reset held", 32'h0, {31'h0, target_reset_out});
    chk("leds reset", 32'h0, {30'h0, led_red, led_green});
    rstn <= 1'b1;
    @(posedge clk);
    exp_q = {LEAD_CHAR};
    for (int i = 0; i < BOOT_LEN; i++)
      exp_q.push_back(BOOT_PROG[i]);
    for (int i = 0; i < 3; i++) begin
      lfsr = lfsr_next(lfsr);
      exp_q.push_back(lfsr);
      ahb(1'b1, 32'h0001_0000, {10'h0, 14'(i), lfsr}, rd);
    end
    ahb(1'b0, {24'h0, STAT_OFF}, 32'h0, rd);
    chk("status idle", 32'h0, rd);
    ahb(1'b0, 32'h0000_00F0, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, {24'h0, CTRL_OFF}, 32'h1, rd);
    wait_for(0, 1, 100);
    chk("tx enable", 32'h0, {31'h0, serial_tx_oen});
    ahb(1'b0, {24'h0, STAT_OFF}, 32'h0, rd);
    chk("status run", (32'h1 << ST_BUSY_BIT) | (32'h1 << ST_RST_BIT), rd);
    wait_for(2, 9, 20000);
    repeat (20000) @(posedge clk);
    chk("red early", 32'h0, {31'h0, led_red});
    prog_voltage_sense <= 1'b1;
    repeat (60) @(posedge clk);
    prog_voltage_sense <= 1'b0;
    repeat (10) @(posedge clk);
    prog_voltage_sense <= 1'b1;
    repeat (90) @(posedge clk);
    chk("red restart", 32'h0, {31'h0, led_red});
    wait_for(1, 1, 40);
    chk("no data yet", 32'd9, 32'(n_rx));
    wait_for(2, 12, 20000);
    wait_for(0, 0, 20000);
    chk("leds fail", 32'h0, {30'h0, led_red, led_green});
    ahb(1'b0, {24'h0, STAT_OFF}, 32'h0, rd);
    chk("status fail", (32'h1 << ST_BUSY_BIT) | (32'h1 << ST_FAIL_BIT), rd);
    ahb(1'b0, {24'h0, COUNT_OFF}, 32'h0, rd);
    chk("verified", 32'h1, rd);
    repeat (1000) @(posedge clk);
    chk("bytes sent", 32'd12, 32'(n_rx));
    results();
  end
endmodule // testbench
